// >>> sim/fsem_master.sv
// Fieldbus master model issuing state requests and clearing errors.
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Master model
module fsem_master (
  input  wire       clk_i,
  input  wire       pend_i,
  output reg        req_valid_o = 1'b0,
  output reg  [3:0] req_state_o = 4'h0,
  output reg        clr_o = 1'b0
);
  task send(input [3:0] s);
    begin
      @(negedge clk_i);
      req_valid_o = 1'b1;
      req_state_o = s;
      @(negedge clk_i);
      req_valid_o = 1'b0;
      // A released target field shows other bits, so a stale value is never mistaken for a request.
      req_state_o = ~s;
    end
  endtask
  task clear;
    integer i;
    begin
      @(negedge clk_i);
      clr_o = 1'b1;
      @(negedge clk_i);
      clr_o = 1'b0;
      for (i = 0; i < 8 && pend_i !== 1'b0; i = i + 1) begin
        @(negedge clk_i);
      end
    end
  endtask
endmodule
`default_nettype wire

// >>> sim/fsem_sva.sv
// Port assertions for the fieldbus state error monitor.
`timescale 1ns/1ps
`default_nettype none
`include "fsem_defines.vh"
// ========================================
// Checker
module fsem_sva (
  input wire       mclk_i, nrst_i, req_valid_i, upgrade_fail_i, desc_mismatch_i, fw_mismatch_i,
  input wire       mbx_boot_bad_i, mbx_cfg_bad_i, err_clear_i, err_pending_o, port_led_o,
  input wire [3:0] req_state_i, state_o, err_sub_o,
  input wire [7:0] err_main_o
);
  wire [11:0] code = {err_main_o, err_sub_o};
  wire        idle = !req_valid_i && !err_pending_o;
  wire        lvl = upgrade_fail_i | desc_mismatch_i | fw_mismatch_i | mbx_cfg_bad_i;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  a_burn_fail_code: assert property (
    idle && upgrade_fail_i && state_o == 4'h3
    |=> code == 12'h805 && $stable(state_o)) else $error("burn failure code wrong");
  a_desc_file_code: assert property (
    idle && desc_mismatch_i && !fw_mismatch_i && state_o == 4'h1
    |=> code == 12'h806 && state_o == 4'h1) else $error("file mismatch code wrong");
  a_fw_hw_code: assert property (
    idle && fw_mismatch_i && !upgrade_fail_i && (state_o == 4'h1 || state_o == 4'h3)
    |=> code == 12'h814 && $stable(state_o)) else $error("firmware code wrong");
  a_bad_target: assert property (
    req_valid_i && !err_pending_o && !lvl && !(req_state_i inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8})
    |=> code == 12'h812) else $error("undefined target code wrong");
  a_op_fallback: assert property (
    req_valid_i && state_o == 4'h8 && req_state_i == 4'h3
    |=> state_o == 4'h4 && err_pending_o) else $error("no fall back to safe state");
  a_init_boot: assert property (
    req_valid_i && state_o == 4'h1 && req_state_i == 4'h3
    |=> state_o == 4'h1 && err_pending_o) else $error("boot request not refused");
  a_mbx_drop: assert property (
    !req_valid_i && state_o == 4'h2 && mbx_cfg_bad_i
    |=> state_o == 4'h1) else $error("no drop to init");
  a_code_hold: assert property (
    err_pending_o && !err_clear_i
    |=> err_pending_o && $stable(code)) else $error("error code not held");
  a_led_lit: assert property (
    $rose(err_pending_o) && err_main_o == 8'h81 && err_sub_o != 4'h4
    |=> port_led_o) else $error("port led not lit");
  a_led_dark: assert property (
    $rose(err_pending_o) && (err_main_o == 8'h80 || code == 12'h814)
    |=> !port_led_o) else $error("port led not dark");
  c_811: cover property ($rose(err_pending_o) && code == 12'h811);
  c_813: cover property ($rose(err_pending_o) && code == 12'h813);
  c_806: cover property ($rose(err_pending_o) && code == 12'h806);
endmodule
bind fsem_monitor fsem_sva u_sva (.*);
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking testbench for the fieldbus state error monitor.
`timescale 1ns/1ps
`default_nettype none
`include "fsem_defines.vh"
`define CHK(a, b) begin checked = checked + 1; if ((a) !== (b)) begin n_mismatch = n_mismatch + 1; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end
// ========================================
// Bench
module tb_top;
  reg         mclk_i = 1'b0;
  reg         nrst_i = 1'b0;
  reg  [4:0]  lv = 5'h00;
  integer     n_mismatch = 0;
  integer     checked = 0;
  integer     cyc = 0;
  wire        req_valid, clr, pend, led;
  wire [3:0]  req_state, state, sub;
  wire [7:0]  e_main;
  always #25 mclk_i = ~mclk_i;
  fsem_master u_m (.clk_i(mclk_i), .pend_i(pend), .req_valid_o(req_valid), .req_state_o(req_state), .clr_o(clr));
  fsem_monitor dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .req_valid_i(req_valid), .req_state_i(req_state),
    .upgrade_fail_i(lv[4]), .desc_mismatch_i(lv[3]), .fw_mismatch_i(lv[2]), .mbx_boot_bad_i(lv[1]),
    .mbx_cfg_bad_i(lv[0]), .err_clear_i(clr), .state_o(state), .err_pending_o(pend), .err_main_o(e_main),
    .err_sub_o(sub), .port_led_o(led));
  task lvl(input [4:0] v);
    begin
      @(negedge mclk_i);
      lv = v;
      @(negedge mclk_i);
      lv = 5'h00;
    end
  endtask
  task chk(input [3:0] s, input [11:0] c);
    begin
      `CHK(state, s)
      `CHK({e_main, sub}, c)
      `CHK(pend, c != 12'h000)
    end
  endtask
  task ledchk(input e);
    begin
      @(negedge mclk_i);
      `CHK(led, e)
    end
  endtask
  task clr_chk;
    begin
      u_m.clear;
      `CHK(pend, 1'b0)
    end
  endtask
  task t_walk;
    begin
      u_m.send(`FSEM_ST_PREOP);
      u_m.send(`FSEM_ST_SAFEOP);
      u_m.send(`FSEM_ST_OP);
      u_m.send(`FSEM_ST_BOOT);
      chk(`FSEM_ST_SAFEOP, `FSEM_ERR_811);
      ledchk(1'b1);
      clr_chk;
    end
  endtask
  task t_target;
    begin
      u_m.send(`FSEM_ST_INIT);
      u_m.send(`FSEM_ST_PREOP);
      u_m.send(4'h7);
      chk(`FSEM_ST_PREOP, `FSEM_ERR_812);
      ledchk(1'b1);
      lvl(5'h01);
      chk(`FSEM_ST_INIT, `FSEM_ERR_812);
      clr_chk;
      u_m.send(`FSEM_ST_PREOP);
      lvl(5'h01);
      chk(`FSEM_ST_INIT, `FSEM_ERR_816);
      ledchk(1'b1);
      clr_chk;
    end
  endtask
  task t_boot;
    begin
      @(negedge mclk_i);
      lv = 5'h02;
      u_m.send(`FSEM_ST_BOOT);
      lv = 5'h00;
      chk(`FSEM_ST_INIT, `FSEM_ERR_815);
      ledchk(1'b1);
      clr_chk;
      u_m.send(`FSEM_ST_BOOT);
      chk(`FSEM_ST_INIT, `FSEM_ERR_813);
      ledchk(1'b1);
      clr_chk;
    end
  endtask
  task t_dark;
    begin
      lvl(5'h10);
      chk(`FSEM_ST_INIT, `FSEM_ERR_NONE);
      lvl(5'h04);
      chk(`FSEM_ST_INIT, `FSEM_ERR_814);
      ledchk(1'b0);
      lvl(5'h08);
      chk(`FSEM_ST_INIT, `FSEM_ERR_814);
      clr_chk;
      lvl(5'h08);
      chk(`FSEM_ST_INIT, `FSEM_ERR_806);
      ledchk(1'b0);
      clr_chk;
    end
  endtask
  task test_done;
    begin
      $display("mismatches %0d, checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask
  // The whole sequence needs fewer than a hundred cycles; the ceiling leaves ample margin.
  always @(posedge mclk_i) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      n_mismatch = n_mismatch + 1;
      test_done;
    end
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    @(negedge mclk_i);
    nrst_i = 1'b1;
    chk(`FSEM_ST_INIT, `FSEM_ERR_NONE);
    t_walk;
    t_target;
    t_boot;
    t_dark;
    test_done;
  end
endmodule
`default_nettype wire

// >>> verilog/fsem_defines.vh
// Constants for the fieldbus state error monitor.
//
// Behaviour
// - A failed firmware burn during a file-transfer upgrade in boot raises error 805, LED dark, state kept; boot is never entered, so 805 is never raised.
// - In init a description file that does not match the firmware raises error 806, LED dark, state kept.
// - A transition request that cannot be made from the present state raises error 811 with a blinking LED.
// - A requested target that is no defined state raises error 812 with a blinking LED.
// - On a request error the state is kept up to safe-operational and operational falls back to safe-operational.
// - A request from init into boot raises protection error 813 with a flickering LED and ends in init.
// - In boot or init, firmware that does not match the hardware raises error 814, LED dark, state kept.
// - On init-to-boot a mailbox setup unfit for boot raises error 815 with a blinking LED and returns to init.
// - In pre-operational an invalid mailbox buffer setup raises error 816 with a blinking LED and drops to init.
`ifndef FSEM_DEFINES_VH
`define FSEM_DEFINES_VH

// Machine state codes.
`define FSEM_ST_INIT    4'h1
`define FSEM_ST_PREOP   4'h2
`define FSEM_ST_BOOT    4'h3
`define FSEM_ST_SAFEOP  4'h4
`define FSEM_ST_OP      4'h8

// Port LED patterns.
`define FSEM_LED_OFF    2'h0
`define FSEM_LED_BLINK  2'h1
`define FSEM_LED_FLICK  2'h2

// Error codes: main in the upper byte as two BCD digits, sub in the low nibble.
`define FSEM_ERR_NONE   12'h000
`define FSEM_ERR_805    12'h805
`define FSEM_ERR_806    12'h806
`define FSEM_ERR_811    12'h811
`define FSEM_ERR_812    12'h812
`define FSEM_ERR_813    12'h813
`define FSEM_ERR_814    12'h814
`define FSEM_ERR_815    12'h815
`define FSEM_ERR_816    12'h816

// Error code fields: main code in the upper byte, sub code in the low nibble.
`define FSEM_MAIN_MSB   11
`define FSEM_MAIN_LSB   4
`define FSEM_SUB_MSB    3
`define FSEM_SUB_LSB    0

// Port LED timing at 20 MHz: blink 200 ms half period, flicker 50 ms.
`define FSEM_BLINK_CYC  22'h3d0900
`define FSEM_FLICK_CYC  22'h0f4240
`define FSEM_CNT_ZERO   22'h000000
`define FSEM_CNT_ONE    22'h000001

`endif

// >>> verilog/fsem_led_gen.v
// Port LED pattern generator for the state error monitor.
`timescale 1ns/1ps
`default_nettype none
`include "fsem_defines.vh"

module fsem_led_gen (
  input  wire       mclk_i,
  input  wire       nrst_i,
  input  wire [1:0] pattern_i,
  output reg        led_o
);

  reg  [21:0] cnt_q;
  wire [21:0] half_w;

  // A pattern change restarts the phase so the first toggle comes after a full half period.
  reg  [1:0]  pat_q;

  assign half_w = (pattern_i == `FSEM_LED_FLICK) ? `FSEM_FLICK_CYC : `FSEM_BLINK_CYC;

  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      cnt_q <= `FSEM_CNT_ZERO;
      pat_q <= `FSEM_LED_OFF;
      led_o <= 1'b0;
    end else begin
      pat_q <= pattern_i;
      if (pattern_i == `FSEM_LED_OFF) begin
        cnt_q <= `FSEM_CNT_ZERO;
        led_o <= 1'b0;
      end else if (pattern_i != pat_q) begin
        cnt_q <= `FSEM_CNT_ZERO;
        led_o <= 1'b1;
      end else if (cnt_q >= half_w - `FSEM_CNT_ONE) begin
        cnt_q <= `FSEM_CNT_ZERO;
        led_o <= ~led_o;
      end else begin
        cnt_q <= cnt_q + `FSEM_CNT_ONE;
      end
    end
  end

endmodule
`default_nettype wire

// >>> verilog/fsem_monitor.v
// Communication state machine with error detection, code display and port LED.
`timescale 1ns/1ps
`default_nettype none
`include "fsem_defines.vh"

module fsem_monitor (
  input  wire        mclk_i,
  input  wire        nrst_i,
  input  wire        req_valid_i,
  input  wire [3:0]  req_state_i,
  input  wire        upgrade_fail_i,
  input  wire        desc_mismatch_i,
  input  wire        fw_mismatch_i,
  input  wire        mbx_boot_bad_i,
  input  wire        mbx_cfg_bad_i,
  input  wire        err_clear_i,
  output reg  [3:0]  state_o,
  output reg         err_pending_o,
  output reg  [7:0]  err_main_o,
  output reg  [3:0]  err_sub_o,
  output wire        port_led_o
);

  // ============================================================
  // Helpers
  // ============================================================
  function is_defined;
    input [3:0] s;
    begin
      case (s)
        `FSEM_ST_INIT:   is_defined = 1'b1;
        `FSEM_ST_PREOP:  is_defined = 1'b1;
        `FSEM_ST_BOOT:   is_defined = 1'b1;
        `FSEM_ST_SAFEOP: is_defined = 1'b1;
        `FSEM_ST_OP:     is_defined = 1'b1;
        default:         is_defined = 1'b0;
      endcase
    end
  endfunction

  // Legal steps: up one level, boot only through init, down to any lower level.
  function is_legal;
    input [3:0] cur;
    input [3:0] tgt;
    begin
      case (cur)
        `FSEM_ST_INIT: begin
          is_legal = (tgt == `FSEM_ST_INIT) || (tgt == `FSEM_ST_PREOP) || (tgt == `FSEM_ST_BOOT);
        end
        `FSEM_ST_BOOT: begin
          is_legal = (tgt == `FSEM_ST_BOOT) || (tgt == `FSEM_ST_INIT);
        end
        `FSEM_ST_PREOP: begin
          is_legal = (tgt != `FSEM_ST_BOOT) && (tgt != `FSEM_ST_OP);
        end
        `FSEM_ST_SAFEOP: begin
          is_legal = (tgt != `FSEM_ST_BOOT);
        end
        `FSEM_ST_OP: begin
          is_legal = (tgt != `FSEM_ST_BOOT);
        end
        default: begin
          is_legal = 1'b0;
        end
      endcase
    end
  endfunction

  // Request error fallback: operational drops to safe-operational, lower states stay.
  function [3:0] fallback;
    input [3:0] cur;
    begin
      fallback = (cur == `FSEM_ST_OP) ? `FSEM_ST_SAFEOP : cur;
    end
  endfunction

  // Local faults stay dark; only the boot protection refusal flickers.
  function [1:0] led_of;
    input [11:0] code;
    begin
      case (code)
        `FSEM_ERR_805: led_of = `FSEM_LED_OFF;
        `FSEM_ERR_806: led_of = `FSEM_LED_OFF;
        `FSEM_ERR_811: led_of = `FSEM_LED_BLINK;
        `FSEM_ERR_812: led_of = `FSEM_LED_BLINK;
        `FSEM_ERR_813: led_of = `FSEM_LED_FLICK;
        `FSEM_ERR_814: led_of = `FSEM_LED_OFF;
        `FSEM_ERR_815: led_of = `FSEM_LED_BLINK;
        `FSEM_ERR_816: led_of = `FSEM_LED_BLINK;
        default:       led_of = `FSEM_LED_OFF;
      endcase
    end
  endfunction

  function [7:0] main_of;
    input [11:0] code;
    begin
      main_of = code[`FSEM_MAIN_MSB:`FSEM_MAIN_LSB];
    end
  endfunction

  function [3:0] sub_of;
    input [11:0] code;
    begin
      sub_of = code[`FSEM_SUB_MSB:`FSEM_SUB_LSB];
    end
  endfunction

  // ============================================================
  // Cause detection
  // ============================================================
  // Each cause counts only in the states in which it can be detected.
  wire        burn_err_w;
  wire        fw_err_w;
  wire        desc_err_w;
  wire        mbx_err_w;
  wire        boot_req_w;

  assign burn_err_w = upgrade_fail_i && (state_o == `FSEM_ST_BOOT);
  assign fw_err_w   = fw_mismatch_i && (state_o == `FSEM_ST_BOOT || state_o == `FSEM_ST_INIT);
  assign desc_err_w = desc_mismatch_i && (state_o == `FSEM_ST_INIT);
  assign mbx_err_w  = mbx_cfg_bad_i && (state_o == `FSEM_ST_PREOP);
  assign boot_req_w = (state_o == `FSEM_ST_INIT) && (req_state_i == `FSEM_ST_BOOT);

  // ============================================================
  // Next state
  // ============================================================
  // Boot is entered only from init, and every such request is refused, so the
  // boot-only checks wait for a boot path that this block does not open.
  reg  [3:0]  state_d;
  reg  [11:0] code_d;
  reg  [1:0]  led_q;

  always @* begin
    state_d = state_o;
    code_d  = `FSEM_ERR_NONE;
    if (burn_err_w) begin
      code_d = `FSEM_ERR_805;
    end else if (fw_err_w) begin
      code_d = `FSEM_ERR_814;
    end else if (desc_err_w) begin
      code_d = `FSEM_ERR_806;
    end else if (mbx_err_w) begin
      code_d  = `FSEM_ERR_816;
      state_d = `FSEM_ST_INIT;
    end else if (req_valid_i) begin
      if (!is_defined(req_state_i)) begin
        code_d  = `FSEM_ERR_812;
        state_d = fallback(state_o);
      end else if (!is_legal(state_o, req_state_i)) begin
        code_d  = `FSEM_ERR_811;
        state_d = fallback(state_o);
      end else if (boot_req_w) begin
        // The mailbox check is reported first; otherwise boot entry is refused.
        if (mbx_boot_bad_i) begin
          code_d = `FSEM_ERR_815;
        end else begin
          code_d = `FSEM_ERR_813;
        end
        state_d = `FSEM_ST_INIT;
      end else begin
        state_d = req_state_i;
      end
    end
  end

  // ============================================================
  // State register
  // ============================================================
  // The state follows every accepted request, even while an older error is still shown.
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      state_o <= `FSEM_ST_INIT;
    end else begin
      state_o <= state_d;
    end
  end

  // ============================================================
  // Held error code
  // ============================================================
  // A pending error is not overwritten, so the first cause stays visible; a new
  // error in the clearing cycle wins over the clear.
  wire        accept_w;

  assign accept_w = (code_d != `FSEM_ERR_NONE) && (!err_pending_o || err_clear_i);

  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      led_q         <= `FSEM_LED_OFF;
      err_pending_o <= 1'b0;
      err_main_o    <= main_of(`FSEM_ERR_NONE);
      err_sub_o     <= sub_of(`FSEM_ERR_NONE);
    end else if (accept_w) begin
      led_q         <= led_of(code_d);
      err_pending_o <= 1'b1;
      err_main_o    <= main_of(code_d);
      err_sub_o     <= sub_of(code_d);
    end else if (err_clear_i) begin
      led_q         <= `FSEM_LED_OFF;
      err_pending_o <= 1'b0;
      err_main_o    <= main_of(`FSEM_ERR_NONE);
      err_sub_o     <= sub_of(`FSEM_ERR_NONE);
    end
  end

  // ============================================================
  // Port LED
  // ============================================================
  fsem_led_gen u_led (
    .mclk_i    (mclk_i),
    .nrst_i    (nrst_i),
    .pattern_i (led_q),
    .led_o     (port_led_o)
  );

endmodule
`default_nettype wire
